// ===== bench/host_cmd_model.sv
// Host model: sends one valid command every fourth cycle while i_run is high.
// Assumes the bench clock; the output changes 1 ns after the rising edge.
`default_nettype none
module host_cmd_model (
  input  wire logic i_clk,
  input  wire logic i_run,
  output var  logic o_cmd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] phase = 2'h0;
  initial o_cmd = 1'b0;
  always @(posedge i_clk)
  begin
    #1;
    phase = phase + 2'h1;
    o_cmd = i_run && (phase == 2'h0);
  end
endmodule
`default_nettype wire

// ===== bench/led_switch_link_watchdog_config_bench.sv
// Bench for the LED switch configuration bank: registers, cluster, groups, override, watchdog.
// Assumes TICK_CYCLES of 4, so code 1 expires 8 cycles after a restart.
`default_nettype none
module led_switch_link_watchdog_config_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_rx_timeout = 1'b0;
  logic i_cluster_call = 1'b0, i_grp_wr = 1'b0, run = 1'b0, cmd;
  logic [7:0] i_reg_addr = 8'h00;
  logic [12:0] i_reg_wdata = 13'h0000, o_reg_rdata;
  logic [5:0] i_rx_cluster_id = 6'h00;
  logic [3:0] i_grp_select = 4'h0;
  logic [11:0] i_sw_normal = 12'h000, i_open_raw = 12'h000, i_short_raw = 12'h000;
  logic [11:0] o_grp_target, o_sw_closed, o_open_fault, o_short_fault;
  logic o_reg_rvalid, o_cluster_accept, o_grp_valid, o_link_timeout, o_fault_n;
  led_cfg_pkg::grp_kind_type i_grp_kind = led_cfg_pkg::GRP_DUTY_A, o_grp_kind;
  int num_errors = 0, checks = 0;
  always #4 i_clk = ~i_clk;
  host_cmd_model host (.i_clk(i_clk), .i_run(run), .o_cmd(cmd));
  led_switch_link_watchdog_config #(.TICK_CYCLES(4)) dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_cmd_valid(cmd), .i_rx_timeout(i_rx_timeout),
    .i_cluster_call(i_cluster_call), .i_rx_cluster_id(i_rx_cluster_id), .o_cluster_accept(o_cluster_accept),
    .i_grp_wr(i_grp_wr), .i_grp_kind(i_grp_kind), .i_grp_select(i_grp_select), .o_grp_valid(o_grp_valid),
    .o_grp_kind(o_grp_kind), .o_grp_target(o_grp_target), .i_sw_normal(i_sw_normal), .o_sw_closed(o_sw_closed),
    .i_open_raw(i_open_raw), .i_short_raw(i_short_raw), .o_open_fault(o_open_fault),
    .o_short_fault(o_short_fault), .o_link_timeout(o_link_timeout), .o_fault_n(o_fault_n));
  task automatic step(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    step();
    i_reg_wr = 1'b0;
    step();
  endtask
  task automatic rd(input logic [7:0] a, input logic [12:0] e);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    step();
    i_reg_rd = 1'b0;
    chk({12'h000, o_reg_rvalid}, 13'h0001);
    chk(o_reg_rdata, e);
    step();
  endtask
  task automatic cl(input logic [5:0] id, input logic e);
    i_cluster_call = 1'b1;
    i_rx_cluster_id = id;
    step();
    i_cluster_call = 1'b0;
    chk({12'h000, o_cluster_accept}, {12'h000, e});
    step();
  endtask
  task automatic grp(input led_cfg_pkg::grp_kind_type k, input logic [3:0] s, input logic [11:0] e);
    i_grp_wr = 1'b1;
    i_grp_kind = k;
    i_grp_select = s;
    step();
    i_grp_wr = 1'b0;
    chk({12'h000, o_grp_valid}, 13'h0001);
    chk({11'h000, o_grp_kind}, {11'h000, k});
    chk({1'b0, o_grp_target}, {1'b0, e});
    step();
  endtask
  // Counts cycles until the timeout flag rises; running out of cycles ends the run.
  task automatic wd_wait(input int lo, input int hi);
    int n;
    n = 0;
    while (o_link_timeout !== 1'b1 && n < hi)
    begin
      step();
      n++;
    end
    chk({12'h000, n >= lo && n < hi}, 13'h0001);
    if (n >= hi)
      results();
  endtask
  initial
  begin
    step(3);
    i_rst = 1'b0;
    step();
    wr(8'h0C, 13'h1FFF);
    rd(8'h0C, 13'h0000);
    rd(8'h07, 13'h0001);
    rd(8'h0A, 13'h0000);
    rd(8'h0B, 13'h0000);
    rd(8'h09, 13'h0000);
    wr(8'h07, 13'h1FFF);
    rd(8'h07, 13'h03FF);
    wr(8'h07, 13'h002A);
    cl(6'h2A, 1'b1);
    cl(6'h01, 1'b0);
    $display("test registers and cluster done");
    wr(8'h0A, 13'h10F0);
    rd(8'h0A, 13'h00F0);
    wr(8'h0B, 13'h000F);
    rd(8'h0B, 13'h000F);
    grp(led_cfg_pkg::GRP_DUTY_A, 4'h0, 12'h0F0);
    grp(led_cfg_pkg::GRP_PHASE, 4'h1, 12'h0F0);
    grp(led_cfg_pkg::GRP_DIM, 4'h1, 12'h0F0);
    grp(led_cfg_pkg::GRP_DUTY_B, 4'h0, 12'h00F);
    grp(led_cfg_pkg::GRP_PHASE, 4'h2, 12'h00F);
    grp(led_cfg_pkg::GRP_DIM, 4'h2, 12'h00F);
    grp(led_cfg_pkg::GRP_DIM, 4'h3, 12'h000);
    $display("test groups done");
    wr(8'h09, 13'h0003);
    i_sw_normal = 12'h0F0;
    i_open_raw = 12'hFFF;
    i_short_raw = 12'hFFF;
    step(4);
    chk({1'b0, o_sw_closed}, 13'h00F3);
    chk({1'b0, o_open_fault}, 13'h0F0C);
    chk({1'b0, o_short_fault}, 13'h0F0C);
    $display("test override done");
    wr(8'h08, 13'h15A5);
    rd(8'h08, 13'h05A5);
    wr(8'h07, 13'h0041);
    wd_wait(6, 16);
    chk({12'h000, o_fault_n}, 13'h0000);
    step();
    chk({1'b0, o_sw_closed}, 13'h05A7);
    run = 1'b1;
    step(6);
    chk({12'h000, o_fault_n}, 13'h0001);
    step(40);
    chk({12'h000, o_link_timeout}, 13'h0000);
    run = 1'b0;
    wr(8'h07, 13'h0081);
    wd_wait(16, 30);
    wr(8'h07, 13'h0001);
    run = 1'b1;
    step(6);
    run = 1'b0;
    step(60);
    chk({12'h000, o_link_timeout}, 13'h0000);
    i_rx_timeout = 1'b1;
    step(2);
    chk({1'b0, o_sw_closed}, 13'h05A7);
    i_rx_timeout = 1'b0;
    $display("test watchdog done");
    wr(8'h0A, 13'h0FFF);
    wr(8'h0B, 13'h0FFF);
    i_rst = 1'b1;
    step(3);
    i_rst = 1'b0;
    step();
    rd(8'h0A, 13'h0000);
    rd(8'h0B, 13'h0000);
    rd(8'h07, 13'h0001);
    chk({12'h000, o_fault_n}, 13'h0001);
    $display("test reset done");
    results();
  end
endmodule
`default_nettype wire

// ===== hw/led_cfg_pkg.sv
// Constants, types and decode helpers for the LED switch configuration bank.
// Assumes a 125 MHz system clock; all users reference names through the package scope.
`default_nettype none

package led_cfg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 13;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SW_N   = 12;
  localparam int unsigned CID_W  = 6;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned TICK_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_LINK_CFG  = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_FALLBACK  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_OVERRIDE  = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_A   = 8'h0A;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_B   = 8'h0B;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned SEL_LSB = 6;
  localparam int unsigned SEL_MSB = 9;
  localparam int unsigned CID_MSB = 5;
  localparam logic [CID_W-1:0] CID_RESET      = 6'h01;
  localparam logic [SEL_W-1:0] SEL_RESET      = 4'h0;
  localparam logic [SW_N-1:0]  FALLBACK_RESET = 12'h000;
  localparam logic [SW_N-1:0]  OVERRIDE_RESET = 12'h000;
  localparam logic [SW_N-1:0]  GROUP_RESET    = 12'h000;
  localparam logic [SEL_W-1:0] SEL_DISABLED   = 4'h0;
  localparam logic [SEL_W-1:0] GROUP_SEL_A    = 4'h1;
  localparam logic [SEL_W-1:0] GROUP_SEL_B    = 4'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned TICK_US     = 100;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

  // Timeout of each select code in microseconds.
  function automatic int unsigned timeout_us(input logic [SEL_W-1:0] code);
    int unsigned us;
    us = 0;
    unique case (code)
      4'h0: us = 0;
      4'h1: us = 200;
      4'h2: us = 500;
      4'h3: us = 1000;
      4'h4: us = 2000;
      4'h5: us = 5000;
      4'h6: us = 10000;
      4'h7: us = 20000;
      4'h8: us = 50000;
      4'h9: us = 100000;
      4'hA: us = 200000;
      4'hB: us = 500000;
      4'hC: us = 1000000;
      4'hD: us = 2000000;
      4'hE: us = 5000000;
      4'hF: us = 5000000;
    endcase
    return us;
  endfunction

  // Timeout expressed in prescaler ticks.
  function automatic logic [TICK_W-1:0] timeout_ticks(input logic [SEL_W-1:0] code);
    return TICK_W'(timeout_us(code) / TICK_US);
  endfunction

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_OFF  = 2'h0,
    WD_RUN  = 2'h1,
    WD_DONE = 2'h3
  } wd_state_type;

  typedef enum logic [1:0] {
    GRP_DUTY_A = 2'h0,
    GRP_DUTY_B = 2'h1,
    GRP_PHASE  = 2'h2,
    GRP_DIM    = 2'h3
  } grp_kind_type;

endpackage

`default_nettype wire

// ===== hw/led_switch_link_watchdog_config.sv
// Configuration bank of a 12-switch LED bypass manager: link watchdog, cluster id,
// force-closed override and group membership, written by the command decoder.
// Assumes the command decoder and dimming engine share i_clk; fault inputs are asynchronous.
`default_nettype none

module led_switch_link_watchdog_config #(
  parameter int unsigned TICK_CYCLES = led_cfg_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_rst,
  // Register access from the command decoder
  input  wire logic                              i_reg_wr,
  input  wire logic                              i_reg_rd,
  input  wire logic [led_cfg_pkg::ADDR_W-1:0]    i_reg_addr,
  input  wire logic [led_cfg_pkg::DATA_W-1:0]    i_reg_wdata,
  output logic [led_cfg_pkg::DATA_W-1:0]         o_reg_rdata,
  output logic                                   o_reg_rvalid,
  // Link events
  input  wire logic                              i_cmd_valid,
  input  wire logic                              i_rx_timeout,
  input  wire logic                              i_cluster_call,
  input  wire logic [led_cfg_pkg::CID_W-1:0]     i_rx_cluster_id,
  output logic                                   o_cluster_accept,
  // Group transactions
  input  wire logic                              i_grp_wr,
  input  wire led_cfg_pkg::grp_kind_type         i_grp_kind,
  input  wire logic [led_cfg_pkg::SEL_W-1:0]     i_grp_select,
  output logic                                   o_grp_valid,
  output led_cfg_pkg::grp_kind_type              o_grp_kind,
  output logic [led_cfg_pkg::SW_N-1:0]           o_grp_target,
  // Switch control
  input  wire logic [led_cfg_pkg::SW_N-1:0]      i_sw_normal,
  output logic [led_cfg_pkg::SW_N-1:0]           o_sw_closed,
  // Fault reporting
  input  wire logic [led_cfg_pkg::SW_N-1:0]      i_open_raw,
  input  wire logic [led_cfg_pkg::SW_N-1:0]      i_short_raw,
  output logic [led_cfg_pkg::SW_N-1:0]           o_open_fault,
  output logic [led_cfg_pkg::SW_N-1:0]           o_short_fault,
  // Status
  output logic                                   o_link_timeout,
  output logic                                   o_fault_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [led_cfg_pkg::SEL_W-1:0]  link_timeout_select;
  logic [led_cfg_pkg::SEL_W-1:0]  next_link_timeout_select;
  logic [led_cfg_pkg::CID_W-1:0]  cluster_identifier;
  logic [led_cfg_pkg::CID_W-1:0]  next_cluster_identifier;
  logic [led_cfg_pkg::SW_N-1:0]   fallback_switch_state;
  logic [led_cfg_pkg::SW_N-1:0]   next_fallback_switch_state;
  logic [led_cfg_pkg::SW_N-1:0]   force_closed_override;
  logic [led_cfg_pkg::SW_N-1:0]   next_force_closed_override;
  logic [led_cfg_pkg::SW_N-1:0]   group_a_members;
  logic [led_cfg_pkg::SW_N-1:0]   next_group_a_members;
  logic [led_cfg_pkg::SW_N-1:0]   group_b_members;
  logic [led_cfg_pkg::SW_N-1:0]   next_group_b_members;
  logic [led_cfg_pkg::DATA_W-1:0] next_reg_rdata;
  logic                           next_reg_rvalid;
  logic                           next_link_timeout;
  logic                           next_cluster_accept;
  logic                           next_grp_valid;
  led_cfg_pkg::grp_kind_type      next_grp_kind;
  logic [led_cfg_pkg::SW_N-1:0]   next_grp_target;
  logic [led_cfg_pkg::SW_N-1:0]   next_sw_closed;
  logic [led_cfg_pkg::SW_N-1:0]   next_open_fault;
  logic [led_cfg_pkg::SW_N-1:0]   next_short_fault;
  logic [led_cfg_pkg::SW_N-1:0]   open_meta;
  logic [led_cfg_pkg::SW_N-1:0]   open_sync;
  logic [led_cfg_pkg::SW_N-1:0]   short_meta;
  logic [led_cfg_pkg::SW_N-1:0]   short_sync;
  logic                           wd_expired;
  logic                           wd_restart;

  // Matches an address against one register offset.
  function automatic logic hit(input logic [led_cfg_pkg::ADDR_W-1:0] addr,
                               input logic [led_cfg_pkg::ADDR_W-1:0] offset);
    return addr == offset;
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb
  begin
    next_link_timeout_select   = link_timeout_select;
    next_cluster_identifier    = cluster_identifier;
    next_fallback_switch_state = fallback_switch_state;
    next_force_closed_override = force_closed_override;
    next_group_a_members       = group_a_members;
    next_group_b_members       = group_b_members;
    if (i_reg_wr && hit(i_reg_addr, led_cfg_pkg::ADDR_LINK_CFG))
    begin
      next_link_timeout_select = i_reg_wdata[led_cfg_pkg::SEL_MSB:led_cfg_pkg::SEL_LSB];
      next_cluster_identifier  = i_reg_wdata[led_cfg_pkg::CID_MSB:0];
    end
    if (i_reg_wr && hit(i_reg_addr, led_cfg_pkg::ADDR_FALLBACK))
    begin
      next_fallback_switch_state = i_reg_wdata[led_cfg_pkg::SW_N-1:0];
    end
    if (i_reg_wr && hit(i_reg_addr, led_cfg_pkg::ADDR_OVERRIDE))
    begin
      next_force_closed_override = i_reg_wdata[led_cfg_pkg::SW_N-1:0];
    end
    if (i_reg_wr && hit(i_reg_addr, led_cfg_pkg::ADDR_GROUP_A))
    begin
      next_group_a_members = i_reg_wdata[led_cfg_pkg::SW_N-1:0];
    end
    if (i_reg_wr && hit(i_reg_addr, led_cfg_pkg::ADDR_GROUP_B))
    begin
      next_group_b_members = i_reg_wdata[led_cfg_pkg::SW_N-1:0];
    end
    next_reg_rvalid = i_reg_rd;
    next_reg_rdata  = '0;
    if (i_reg_rd)
    begin
      if (hit(i_reg_addr, led_cfg_pkg::ADDR_LINK_CFG))
      begin
        next_reg_rdata = {3'h0, link_timeout_select, cluster_identifier};
      end
      else if (hit(i_reg_addr, led_cfg_pkg::ADDR_FALLBACK))
      begin
        next_reg_rdata = {1'b0, fallback_switch_state};
      end
      else if (hit(i_reg_addr, led_cfg_pkg::ADDR_OVERRIDE))
      begin
        next_reg_rdata = {1'b0, force_closed_override};
      end
      else if (hit(i_reg_addr, led_cfg_pkg::ADDR_GROUP_A))
      begin
        next_reg_rdata = {1'b0, group_a_members};
      end
      else if (hit(i_reg_addr, led_cfg_pkg::ADDR_GROUP_B))
      begin
        next_reg_rdata = {1'b0, group_b_members};
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      link_timeout_select   <= led_cfg_pkg::SEL_RESET;
      cluster_identifier    <= led_cfg_pkg::CID_RESET;
      fallback_switch_state <= led_cfg_pkg::FALLBACK_RESET;
      force_closed_override <= led_cfg_pkg::OVERRIDE_RESET;
      group_a_members       <= led_cfg_pkg::GROUP_RESET;
      group_b_members       <= led_cfg_pkg::GROUP_RESET;
      o_reg_rdata           <= '0;
      o_reg_rvalid          <= 1'b0;
    end
    else
    begin
      link_timeout_select   <= next_link_timeout_select;
      cluster_identifier    <= next_cluster_identifier;
      fallback_switch_state <= next_fallback_switch_state;
      force_closed_override <= next_force_closed_override;
      group_a_members       <= next_group_a_members;
      group_b_members       <= next_group_b_members;
      o_reg_rdata           <= next_reg_rdata;
      o_reg_rvalid          <= next_reg_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Link watchdog
  // ----------------------------------------------------------------
  // A write to the link register also restarts, so a new duration counts from zero.
  assign wd_restart = i_cmd_valid | (i_reg_wr & hit(i_reg_addr, led_cfg_pkg::ADDR_LINK_CFG));

  link_watchdog_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_select  (link_timeout_select),
    .i_restart (wd_restart),
    .o_expired (wd_expired)
  );

  // Expiry wins over a command in the same cycle; a later command clears the flag.
  always_comb
  begin
    next_link_timeout = o_link_timeout;
    if (wd_expired)
    begin
      next_link_timeout = 1'b1;
    end
    else if (i_cmd_valid)
    begin
      next_link_timeout = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_link_timeout <= 1'b0;
      o_fault_n      <= 1'b1;
    end
    else
    begin
      o_link_timeout <= next_link_timeout;
      o_fault_n      <= ~next_link_timeout;
    end
  end

  // ----------------------------------------------------------------
  // Cluster call and group routing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cluster_accept = i_cluster_call && (i_rx_cluster_id == cluster_identifier);
    next_grp_valid      = i_grp_wr;
    next_grp_kind       = i_grp_kind;
    next_grp_target     = '0;
    if (i_grp_wr)
    begin
      unique case (i_grp_kind)
        led_cfg_pkg::GRP_DUTY_A: next_grp_target = group_a_members;
        led_cfg_pkg::GRP_DUTY_B: next_grp_target = group_b_members;
        led_cfg_pkg::GRP_PHASE, led_cfg_pkg::GRP_DIM:
        begin
          if (i_grp_select == led_cfg_pkg::GROUP_SEL_A)
          begin
            next_grp_target = group_a_members;
          end
          else if (i_grp_select == led_cfg_pkg::GROUP_SEL_B)
          begin
            next_grp_target = group_b_members;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_cluster_accept <= 1'b0;
      o_grp_valid      <= 1'b0;
      o_grp_kind       <= led_cfg_pkg::GRP_DUTY_A;
      o_grp_target     <= '0;
    end
    else
    begin
      o_cluster_accept <= next_cluster_accept;
      o_grp_valid      <= next_grp_valid;
      o_grp_kind       <= next_grp_kind;
      o_grp_target     <= next_grp_target;
    end
  end

  // ----------------------------------------------------------------
  // Switch drive and fault gating
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    open_meta  <= i_open_raw;
    open_sync  <= open_meta;
    short_meta <= i_short_raw;
    short_sync <= short_meta;
  end

  // Override has the last word, so a forced switch stays closed even in fallback.
  always_comb
  begin
    next_sw_closed = i_sw_normal;
    if (o_link_timeout || i_rx_timeout)
    begin
      next_sw_closed = fallback_switch_state;
    end
    next_sw_closed   = next_sw_closed | force_closed_override;
    next_open_fault  = open_sync & ~next_sw_closed;
    next_short_fault = short_sync & ~next_sw_closed;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_sw_closed   <= '0;
      o_open_fault  <= '0;
      o_short_fault <= '0;
    end
    else
    begin
      o_sw_closed   <= next_sw_closed;
      o_open_fault  <= next_open_fault;
      o_short_fault <= next_short_fault;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_disabled;
    (link_timeout_select == led_cfg_pkg::SEL_DISABLED) [*2];
  endsequence

  sequence s_timed_out;
    o_link_timeout && !i_rx_timeout;
  endsequence

  property p_off_never_expires;
    s_disabled |-> !wd_expired;
  endproperty
  a_off_never_expires: assert property (p_off_never_expires) else $error("watchdog expired while off");

  property p_flag_cause;
    $rose(o_link_timeout) |-> $past(wd_expired);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("timeout flag rose without expiry");

  property p_fault_pin;
    o_fault_n == !o_link_timeout;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault output disagrees with flag");

  property p_fallback;
    s_timed_out |=> o_sw_closed == ($past(fallback_switch_state) | $past(force_closed_override));
  endproperty
  a_fallback: assert property (p_fallback) else $error("switches not in fallback state");

  property p_rx_fallback;
    i_rx_timeout |=> o_sw_closed == ($past(fallback_switch_state) | $past(force_closed_override));
  endproperty
  a_rx_fallback: assert property (p_rx_fallback) else $error("receive timeout fallback missed");

  property p_cluster;
    i_cluster_call |=> o_cluster_accept == ($past(i_rx_cluster_id) == $past(cluster_identifier));
  endproperty
  a_cluster: assert property (p_cluster) else $error("cluster accept wrong");

  property p_override;
    1'b1 |=> (o_sw_closed & $past(force_closed_override)) == $past(force_closed_override);
  endproperty
  a_override: assert property (p_override) else $error("override switch not closed");

  property p_fault_gate;
    ((o_open_fault | o_short_fault) & o_sw_closed) == '0;
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault reported on closed switch");

  property p_group_a_write;
    i_reg_wr && i_reg_addr == led_cfg_pkg::ADDR_GROUP_A
      |=> group_a_members == $past(i_reg_wdata[led_cfg_pkg::SW_N-1:0]);
  endproperty
  a_group_a_write: assert property (p_group_a_write) else $error("group A not written");

  property p_group_a_route;
    i_grp_wr && i_grp_kind != led_cfg_pkg::GRP_DUTY_B && i_grp_kind != led_cfg_pkg::GRP_DUTY_A
      && i_grp_select == led_cfg_pkg::GROUP_SEL_A |=> o_grp_valid && o_grp_target == $past(group_a_members);
  endproperty
  a_group_a_route: assert property (p_group_a_route) else $error("group A routing wrong");

  property p_group_b_route;
    i_grp_wr && i_grp_kind == led_cfg_pkg::GRP_DUTY_B |=> o_grp_target == $past(group_b_members);
  endproperty
  a_group_b_route: assert property (p_group_b_route) else $error("group B duty routing wrong");

  property p_restart;
    i_cmd_valid |=> !wd_expired [*2];
  endproperty
  a_restart: assert property (p_restart) else $error("watchdog expired right after a command");

endmodule

`default_nettype wire

// ===== hw/link_watchdog_timer.sv
// Link watchdog counter: a prescaler of fixed ticks and a tick counter per timeout code.
// Assumes restart and select come from logic on the same clock.
`default_nettype none

module link_watchdog_timer #(
  parameter int unsigned TICK_CYCLES = led_cfg_pkg::TICK_CYCLES,
  parameter int unsigned PRESC_W     = 24
) (
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst,
  // Control
  input  wire logic [led_cfg_pkg::SEL_W-1:0]  i_select,
  input  wire logic                           i_restart,
  // Result
  output logic                                o_expired
);

  led_cfg_pkg::wd_state_type         state;
  led_cfg_pkg::wd_state_type         next_state;
  logic [PRESC_W-1:0]                presc;
  logic [PRESC_W-1:0]                next_presc;
  logic [led_cfg_pkg::TICK_W-1:0]    ticks;
  logic [led_cfg_pkg::TICK_W-1:0]    next_ticks;
  logic                              next_expired;
  logic [led_cfg_pkg::TICK_W-1:0]    limit;

  assign limit = led_cfg_pkg::timeout_ticks(i_select);

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state   = state;
    next_presc   = presc;
    next_ticks   = ticks;
    next_expired = 1'b0;
    if (i_select == led_cfg_pkg::SEL_DISABLED)
    begin
      next_state = led_cfg_pkg::WD_OFF;
      next_presc = '0;
      next_ticks = '0;
    end
    else if (i_restart)
    begin
      next_state = led_cfg_pkg::WD_RUN;
      next_presc = '0;
      next_ticks = '0;
    end
    else
    begin
      unique case (state)
        led_cfg_pkg::WD_OFF:
        begin
          next_state = led_cfg_pkg::WD_RUN;
        end
        led_cfg_pkg::WD_RUN:
        begin
          if (presc == PRESC_W'(TICK_CYCLES - 1))
          begin
            next_presc = '0;
            if (ticks + 1'b1 >= limit)
            begin
              next_state   = led_cfg_pkg::WD_DONE;
              next_expired = 1'b1;
            end
            else
            begin
              next_ticks = ticks + 1'b1;
            end
          end
          else
          begin
            next_presc = presc + 1'b1;
          end
        end
        led_cfg_pkg::WD_DONE:
        begin
          next_state = led_cfg_pkg::WD_DONE;
        end
        default:
        begin
          next_state = led_cfg_pkg::WD_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state     <= led_cfg_pkg::WD_OFF;
      presc     <= '0;
      ticks     <= '0;
      o_expired <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      presc     <= next_presc;
      ticks     <= next_ticks;
      o_expired <= next_expired;
    end
  end

endmodule

`default_nettype wire
